//--- logic/timer_ctl1.sv
// Second control register of the timer: master trigger, idle levels, trigger input, DMA, commutation
//
// Contract
// RQ1 - Software uses only whole 32-bit word accesses to this register.
// RQ2 - Software writes reserved upper bits 31:16 as zero.
// RQ3 - Bit 8 gives channel 0 main output level while primary output is disabled.
// RQ4 - Bit 9 gives channel 0 complementary output level while primary output is disabled.
// RQ5 - Main output goes idle only after dead time when a complementary output exists.
// RQ6 - Idle-level bits change only when lock level is 00; otherwise writes ignored.
// RQ7 - Bits 10..15 give idle levels of channels 1..3, even main, odd complementary.
// RQ8 - Bit 7 picks channel 0 trigger: pin 0, or XOR of pins 0,1,2.
// RQ9 - Mode 000 pulses master trigger on counter reset from master or update-generate.
// RQ10 - Mode 001 pulses master trigger on counter start or trigger high in pause.
// RQ11 - Mode 010 pulses master trigger on every counted update event.
// RQ12 - Mode 011 pulses master trigger on channel 0 capture/compare pulse.
// RQ13 - Modes 100..111 make master trigger follow compare references of channels 0..3; the code gives a one-cycle pulse on each rising edge instead.
// RQ14 - Bit 3 picks channel DMA request source: capture/compare or update event.
// RQ15 - Bit 0 shadows enables and compare control until the next commutation event.
// RQ16 - Bit 2 adds trigger rising edge to commutation-generate as shadow load source.
// RQ17 - Channels without complementary output ignore commutation shadow enable and source.
// RQ18 - Update-disable suppresses update events; update-generate still reinitialises counter.
// RQ19 - Each master trigger event is a single clock pulse.
// RQ20 - All register fields reset to zero.
//
// Added by the designer: the strobed register port.
`include "timer_ctl1_map.svh"
module timer_ctl1 #(
  parameter int NUM_CH = 4,
  parameter logic [3:0] HAS_COMP = 4'h7,
  parameter int DEAD_CYC = `DEADTIME_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Counter events from the timer core
  input wire logic master_reset_event,
  input wire logic counter_run_bit,
  input wire logic pause_trigger_high,
  input wire logic overflow_event,
  input wire logic restart_event,
  input wire logic update_disable_bit,
  input wire logic update_source_bit,
  input wire logic [3:0] cc_event,
  input wire logic [3:0] compare_reference,
  input wire logic slave_trigger_input,
  input wire logic primary_output_enable,
  // Channel pins and active drive
  input wire logic [2:0] ch_pin,
  input wire logic [3:0] main_active,
  input wire logic [3:0] comp_active,
  // Outputs
  output logic master_trigger_output,
  output logic counter_init,
  output logic ch0_trigger_input,
  output logic [3:0] dma_request,
  output logic [3:0] channel_output_enable,
  output logic [3:0] comp_output_enable,
  output logic [3:0] output_compare_control,
  output logic [3:0] main_out,
  output logic [3:0] comp_out
);
  import timer_ctl1_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] ctl1_q, ctl1_d;
  logic [11:0] chen_q, chen_d;
  logic [11:0] live_q, live_d;
  logic [1:0] lock_q, lock_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] pin_s1_q, pin_s2_q;
  logic trg_s1_q, trg_s2_q, trg_prev_q;
  logic trig_q, trig_d, init_q, init_d, cnt_run_prev_q, ref_prev_q, ref_prev_d;
  logic tin_q, tin_d;
  logic [3:0] dma_q, dma_d;
  logic update_generate_bit, commutation_generate_bit, upd_evt, start_evt, cmt_evt, ref_sel;
  master_mode_t mode;

  // Write merge under a mask, shared by the control and channel enable registers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign update_generate_bit = reg_wr && reg_addr == `SWEV_OFFSET && reg_wdata[`BIT_UPG];
  assign commutation_generate_bit = reg_wr && reg_addr == `SWEV_OFFSET && reg_wdata[`BIT_COMMUTATION_GENERATE_BIT];
  // Suppressed entirely by update-disable; source bit drops update-generate and restart, leaving only overflow
  assign upd_evt = !update_disable_bit && (overflow_event ||
                   (!update_source_bit && (update_generate_bit || restart_event))); // RQ18
  assign start_evt = (counter_run_bit && !cnt_run_prev_q) || pause_trigger_high;
  assign cmt_evt = commutation_generate_bit || (ctl1_q[`BIT_COMMUTATION_UPDATE_SOURCE] && trg_s2_q && !trg_prev_q); // RQ16
  assign mode = master_mode_t'(ctl1_q[`BIT_MMC_HI:`BIT_MMC_LO]);
  assign ref_sel = compare_reference[ctl1_q[5:4]];

  // ----------------------------------------------------------------
  // Register port and trigger logic, next values
  // ----------------------------------------------------------------
  always_comb begin
    ctl1_d = ctl1_q;
    chen_d = chen_q;
    lock_d = lock_q;
    rdata_d = 32'h00000000;
    live_d = live_q;
    trig_d = 1'b0;
    init_d = update_generate_bit || restart_event || master_reset_event; // RQ18
    ref_prev_d = ref_sel;
    if (reg_wr) begin
      if (reg_addr == `CTL1_OFFSET) begin
        // Idle levels stay frozen while configuration lock is raised
        if (lock_q == `LOCK_OPEN) begin
          ctl1_d = merge(ctl1_q, reg_wdata[15:0], `CTL1_WMASK); // RQ6
        end else begin
          ctl1_d = merge(ctl1_q, reg_wdata[15:0], `CTL1_WMASK & 16'h00FF); // RQ6
        end
      end else if (reg_addr == `CHEN_OFFSET) begin
        chen_d = 12'(merge({4'h0, chen_q}, reg_wdata[15:0], `CHEN_WMASK));
      end else if (reg_addr == `LOCK_OFFSET) begin
        lock_d = reg_wdata[1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `CTL1_OFFSET) begin
        rdata_d = {16'h0000, ctl1_q};
      end else if (reg_addr == `CHEN_OFFSET) begin
        rdata_d = {20'h00000, chen_q};
      end else if (reg_addr == `LOCK_OFFSET) begin
        rdata_d = {30'h00000000, lock_q};
      end else if (reg_addr == `STAT_OFFSET) begin
        rdata_d = {16'h0000, main_out, comp_out, 4'h0, 3'h0, trig_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    // Per channel: shadowed only with comp output and shadowing on
    for (int i = 0; i < NUM_CH; i++) begin
      if (!(HAS_COMP[i] && ctl1_q[`BIT_COMMUTATION_SHADOW_ENABLE]) || cmt_evt) begin // RQ15 RQ17
        live_d[3*i +: 3] = chen_q[3*i +: 3];
      end
    end
    // Master trigger selection
    case (mode)
      MM_RESET: trig_d = update_generate_bit || master_reset_event; // RQ9
      MM_ENABLE: trig_d = start_evt; // RQ10
      MM_UPDATE: trig_d = upd_evt; // RQ11
      MM_CMP_PULSE: trig_d = cc_event[0]; // RQ12
      default: trig_d = ref_sel && !ref_prev_q; // RQ13 RQ19
    endcase
  end

  // Channel 0 trigger input and DMA source
  always_comb begin
    tin_d = ctl1_q[`BIT_CH0_TRIGGER_INPUT_SELECT] ? ^pin_s2_q : pin_s2_q[0]; // RQ8
    dma_d = ctl1_q[`BIT_DMA_SOURCE_SELECT] ? {4{upd_evt}} : cc_event; // RQ14
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl1_q <= `CTL1_RESET; // RQ20
      chen_q <= 12'h000;
      live_q <= 12'h000;
      lock_q <= `LOCK_RESET;
      rdata_q <= 32'h00000000;
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_prev_q <= 1'b0;
      trig_q <= 1'b0;
      init_q <= 1'b0;
      cnt_run_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
      tin_q <= 1'b0;
      dma_q <= 4'h0;
    end else begin
      ctl1_q <= ctl1_d;
      chen_q <= chen_d;
      live_q <= live_d;
      lock_q <= lock_d;
      rdata_q <= rdata_d;
      pin_s1_q <= ch_pin;
      pin_s2_q <= pin_s1_q;
      trg_s1_q <= slave_trigger_input;
      trg_s2_q <= trg_s1_q;
      trg_prev_q <= trg_s2_q;
      trig_q <= trig_d;
      init_q <= init_d;
      cnt_run_prev_q <= counter_run_bit;
      ref_prev_q <= ref_prev_d;
      tin_q <= tin_d;
      dma_q <= dma_d;
    end
  end

  // ----------------------------------------------------------------
  // Output stages, one per channel
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_out
    idle_output_stage #(
      .DEAD_CYC(DEAD_CYC)
    ) u_stage (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .primary_output_enable(primary_output_enable),
      .has_comp(HAS_COMP[g]),
      .main_idle_level(ctl1_q[`BIT_IDLE_LO + 2*g]), // RQ7
      .comp_idle_level(ctl1_q[`BIT_IDLE_LO + 2*g + 1]), // RQ7
      .main_active(main_active[g]),
      .comp_active(comp_active[g]),
      .main_out(main_out[g]),
      .comp_out(comp_out[g])
    );
  end

  // Output wiring
  assign reg_rdata = rdata_q;
  assign master_trigger_output = trig_q;
  assign counter_init = init_q;
  assign ch0_trigger_input = tin_q;
  assign dma_request = dma_q;
  for (genvar c = 0; c < 4; c++) begin : g_en
    assign channel_output_enable[c] = live_q[3*c];
    assign comp_output_enable[c] = live_q[3*c + 1];
    assign output_compare_control[c] = live_q[3*c + 2];
  end
endmodule

//--- common/timer_ctl1_map.svh
// Register offsets, field positions, reset values and timing counts for the control block
`ifndef TIMER_CTL1_MAP_SVH
`define TIMER_CTL1_MAP_SVH
`define CTL1_OFFSET 8'h04
`define CTL1_RESET 16'h0000
`define CTL1_WMASK 16'hFFFD
`define CHEN_OFFSET 8'h20
`define CHEN_RESET 16'h0000
`define CHEN_WMASK 16'h0FFF
`define STAT_OFFSET 8'h24
`define SWEV_OFFSET 8'h14
`define LOCK_OFFSET 8'h44
`define LOCK_RESET 2'h0
`define LOCK_OPEN 2'h0
`define BIT_COMMUTATION_SHADOW_ENABLE 0
`define BIT_COMMUTATION_UPDATE_SOURCE 2
`define BIT_DMA_SOURCE_SELECT 3
`define BIT_MMC_LO 4
`define BIT_MMC_HI 6
`define BIT_CH0_TRIGGER_INPUT_SELECT 7
`define BIT_IDLE_LO 8
`define BIT_IDLE_HI 15
`define BIT_UPG 0
`define BIT_COMMUTATION_GENERATE_BIT 5
`define DEADTIME_NS 200
`define CLK_PERIOD_NS 50
`define DEADTIME_CYC ((`DEADTIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- common/timer_ctl1_pkg.sv
// Types shared by the control block and its output stage
package timer_ctl1_pkg;
  typedef enum logic [2:0] {
    MM_RESET = 3'b000,
    MM_ENABLE = 3'b001,
    MM_UPDATE = 3'b010,
    MM_CMP_PULSE = 3'b011,
    MM_REF0 = 3'b100,
    MM_REF1 = 3'b101,
    MM_REF2 = 3'b110,
    MM_REF3 = 3'b111
  } master_mode_t;
  typedef enum logic [1:0] {
    OS_ACTIVE = 2'b00,
    OS_COMP_IDLE = 2'b01,
    OS_MAIN_IDLE = 2'b10
  } out_state_t;
endpackage

//--- logic/idle_output_stage.sv
// One channel output pair that falls to its idle levels, complementary first when the channel has one
`include "timer_ctl1_map.svh"
module idle_output_stage #(
  parameter int DEAD_CYC = `DEADTIME_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic primary_output_enable,
  input wire logic has_comp,
  input wire logic main_idle_level,
  input wire logic comp_idle_level,
  // Active drive from compare logic
  input wire logic main_active,
  input wire logic comp_active,
  // Pins
  output logic main_out,
  output logic comp_out
);
  import timer_ctl1_pkg::*;
  out_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic main_out_q, main_out_d, comp_out_q, comp_out_d;

  // Next state; with a complementary output, the main output waits out the dead time, holding its last level
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    main_out_d = main_active;
    comp_out_d = has_comp ? comp_active : 1'b0;
    case (state_q)
      OS_ACTIVE: begin
        if (!primary_output_enable) begin
          comp_out_d = has_comp ? comp_idle_level : 1'b0; // RQ4
          main_out_d = main_out_q;
          cnt_d = 8'(DEAD_CYC);
          state_d = has_comp ? OS_COMP_IDLE : OS_MAIN_IDLE; // RQ5
          if (!has_comp) begin
            main_out_d = main_idle_level; // RQ3
          end
        end
      end
      OS_COMP_IDLE: begin
        comp_out_d = comp_idle_level; // RQ4
        main_out_d = main_out_q;
        if (primary_output_enable) begin
          state_d = OS_ACTIVE;
        end else if (cnt_q <= 8'h01) begin
          main_out_d = main_idle_level; // RQ5
          state_d = OS_MAIN_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      OS_MAIN_IDLE: begin
        main_out_d = main_idle_level; // RQ3
        comp_out_d = has_comp ? comp_idle_level : 1'b0;
        if (primary_output_enable) begin
          state_d = OS_ACTIVE;
        end
      end
      default: state_d = OS_ACTIVE;
    endcase
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= OS_ACTIVE;
      cnt_q <= 8'h00;
      main_out_q <= 1'b0;
      comp_out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      main_out_q <= main_out_d;
      comp_out_q <= comp_out_d;
    end
  end

  assign main_out = main_out_q;
  assign comp_out = comp_out_q;
endmodule

//--- verif/timer_ctl1_chk.sv
// Checker on the ports of the second timer control block
module timer_ctl1_chk #(
  parameter int DEAD_CYC = 4
) (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Event causes
  input wire logic master_reset_event,
  input wire logic counter_run_bit,
  input wire logic overflow_event,
  input wire logic restart_event,
  input wire logic update_disable_bit,
  input wire logic [3:0] cc_event,
  input wire logic [3:0] compare_reference,
  input wire logic [2:0] ch_pin,
  input wire logic primary_output_enable,
  // Watched outputs
  input wire logic master_trigger_output,
  input wire logic counter_init,
  input wire logic ch0_trigger_input,
  input wire logic [3:0] dma_request,
  input wire logic [3:0] main_out,
  input wire logic [3:0] comp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLO = DEAD_CYC + 1;
  logic [15:0] c_q;
  logic [1:0] lk_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Mirror of the control word; idle bits obey the lock like the device
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      c_q <= 16'h0000;
      lk_q <= 2'h0;
    end else if (reg_wr && reg_addr == 8'h44) begin
      lk_q <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == 8'h04) begin
      c_q[7:0] <= reg_wdata[7:0];
      if (lk_q == 2'h0) c_q[15:8] <= reg_wdata[15:8];
    end
  end
  // Trigger output per master mode
  mode_reset_a: assert property (c_q[6:4] == 3'h0 && master_reset_event |=> master_trigger_output)
    else $error("reset mode trigger missing");
  mode_start_a: assert property (c_q[6:4] == 3'h1 && $rose(counter_run_bit) |=> master_trigger_output)
    else $error("start mode trigger missing");
  mode_update_a: assert property (c_q[6:4] == 3'h2 && overflow_event && !update_disable_bit |=> master_trigger_output)
    else $error("update mode trigger missing");
  mode_ccpulse_a: assert property (c_q[6:4] == 3'h3 && cc_event[0] |=> master_trigger_output)
    else $error("capture mode trigger missing");
  mode_ref_a: assert property (c_q[6] && $rose(compare_reference[c_q[5:4]]) |=> master_trigger_output)
    else $error("reference mode trigger missing");
  single_pulse_a: assert property (master_trigger_output |=> !master_trigger_output)
    else $error("trigger wider than one cycle");
  init_nodis_a: assert property (update_disable_bit && restart_event |=> counter_init)
    else $error("counter init missing");
  dma_cc_a: assert property (!c_q[3] && cc_event[1] |=> dma_request[1])
    else $error("dma request missing");
  // Trigger select; the window skips a recent change of the select bit
  trig_sel_a: assert property (c_q[7] == $past(c_q[7], 3) |-> ch0_trigger_input ==
    (c_q[7] ? ^$past(ch_pin, 3) : $past(ch_pin[0], 3))) else $error("trigger input wrong");
  comp_idle_a: assert property ($fell(primary_output_enable) |=> comp_out[0] == c_q[9])
    else $error("complementary idle level wrong");
  main_idle_a: assert property ($fell(primary_output_enable) |-> ##DLO main_out[0] == c_q[8])
    else $error("main idle level wrong");
  // Main scenarios
  trig_c: cover property (master_trigger_output);
  idle_c: cover property ($fell(primary_output_enable));
  dma_c: cover property (dma_request[1]);
endmodule
bind timer_ctl1 timer_ctl1_chk #(.DEAD_CYC(DEAD_CYC)) chk (.*);

//--- verif/slave_timer_model.sv
// Slave timer that counts master trigger pulses
module slave_timer_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Trigger from the master
  input wire logic master_trigger_output,
  // Observations
  output logic [7:0] pulses,
  output logic long_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  // A slave sees edges, so a level held twice would read as one event
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {prev_q, pulses, long_pulse} <= '0;
    end else begin
      prev_q <= master_trigger_output;
      if (master_trigger_output && !prev_q) pulses <= pulses + 8'h01;
      if (master_trigger_output && prev_q) long_pulse <= 1'h1;
    end
  end
endmodule

//--- verif/timer_ctl1_tb_top.sv
// Self-checking bench for the second timer control block
module timer_ctl1_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_ctl1_pkg::*;
  localparam int DC = 4;
  logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, pulses, p0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic master_reset_event = 1'h0, counter_run_bit = 1'h0, pause_trigger_high = 1'h0;
  logic overflow_event = 1'h0, restart_event = 1'h0, update_disable_bit = 1'h0;
  logic update_source_bit = 1'h0, slave_trigger_input = 1'h0, primary_output_enable = 1'h1;
  logic [3:0] cc_event = 4'h0, compare_reference = 4'h0, main_active = 4'hF, comp_active = 4'h0;
  logic [2:0] ch_pin = 3'h0;
  logic master_trigger_output, counter_init, ch0_trigger_input, long_pulse;
  logic [3:0] dma_request, channel_output_enable, comp_output_enable, output_compare_control;
  logic [3:0] main_out, comp_out;
  int fails = 0, samples_checked = 0;
  timer_ctl1 #(.DEAD_CYC(DC)) DUT (.*);
  slave_timer_model partner (.*);
  always #25 sys_clk = ~sys_clk;
  // Bus cycles: whole words, upper half always zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One cause per master mode; event pulses last one cycle, run bit and compare reference stay high
  task automatic cause(input int m);
    @(posedge sys_clk);
    case (m)
      0: master_reset_event <= 1'h1;
      1: counter_run_bit <= 1'h1;
      2: {overflow_event, restart_event} <= 2'h3;
      3: cc_event <= 4'h3;
      default: compare_reference <= 4'(1 << (m - 4));
    endcase
    @(posedge sys_clk);
    {master_reset_event, overflow_event, restart_event, cc_event} <= '0;
    tick(3);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #200us;
    fails++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd(8'h04, rv);
    chk("ctl reset", 32'h0, rv);
    rd(8'h3C, rv);
    chk("unmapped", 32'h0, rv);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(8'h04, 32'(m) << 4);
      p0 = pulses;
      cause(m);
      chk("trigger", {24'h0, p0 + 8'h01}, {24'h0, pulses});
      @(posedge sys_clk);
      {counter_run_bit, compare_reference} <= '0;
    end
    wr(8'h04, 32'h0);
    p0 = pulses;
    wr(8'h14, 32'h1);
    tick(3);
    chk("upg trigger", {24'h0, p0 + 8'h01}, {24'h0, pulses});
    wr(8'h04, 32'h20);
    update_disable_bit <= 1'h1;
    p0 = pulses;
    cause(2);
    chk("no update", {24'h0, p0}, {24'h0, pulses});
    @(posedge sys_clk);
    update_disable_bit <= 1'h0;
    chk("long pulse", 32'h0, {31'h0, long_pulse});
    $display("test master modes done");
    wr(8'h04, 32'h80);
    ch_pin <= 3'h3;
    tick(5);
    chk("xor sel", 32'h0, {31'h0, ch0_trigger_input});
    @(posedge sys_clk);
    ch_pin <= 3'h7;
    tick(5);
    chk("xor sel", 32'h1, {31'h0, ch0_trigger_input});
    wr(8'h04, 32'h0);
    ch_pin <= 3'h3;
    tick(5);
    chk("pin sel", 32'h1, {31'h0, ch0_trigger_input});
    $display("test trigger input done");
    wr(8'h04, 32'hAA00);
    @(posedge sys_clk);
    primary_output_enable <= 1'h0;
    tick(2);
    chk("comp idle", 32'h7, {29'h0, comp_out[2:0]});
    chk("main dead", 32'h7, {28'h0, main_out});
    tick(DC);
    chk("main idle", 32'h0, {28'h0, main_out});
    wr(8'h44, 32'h1);
    wr(8'h04, 32'h0);
    rd(8'h04, rv);
    chk("locked idle", 32'hAA00, rv);
    wr(8'h44, 32'h0);
    primary_output_enable <= 1'h1;
    $display("test idle done");
    wr(8'h20, 32'h1);
    tick(2);
    chk("direct en", 32'h1, {28'h0, channel_output_enable});
    wr(8'h04, 32'h1);
    wr(8'h20, 32'h249);
    tick(2);
    chk("shadow held", 32'h9, {28'h0, channel_output_enable});
    wr(8'h14, 32'h20);
    tick(2);
    chk("cmt load", 32'hF, {28'h0, channel_output_enable});
    wr(8'h04, 32'h5);
    wr(8'h20, 32'h0);
    tick(2);
    chk("shadow held", 32'h7, {28'h0, channel_output_enable});
    @(posedge sys_clk);
    slave_trigger_input <= 1'h1;
    tick(6);
    chk("trig load", 32'h0, {28'h0, channel_output_enable});
    // Shadowing off: every enable and compare control bit lands at once
    wr(8'h04, 32'h0);
    wr(8'h20, 32'hFFF);
    tick(2);
    chk("all en", 32'hF, {28'h0, channel_output_enable});
    chk("all comp en", 32'hF, {28'h0, comp_output_enable});
    chk("all cmp ctl", 32'hF, {28'h0, output_compare_control});
    $display("test commutation done");
    summarize();
  end
endmodule
